/* File: verilog/rar_defs.svh */
// Constants for the refresh and display bus arbiter.
// Assumes inclusion by bare name from the arbiter's package or module.
`ifndef RAR_DEFS_SVH
`define RAR_DEFS_SVH

// Inactive level of every active-low control output
`define RAR_NEG 1'h1
// Active level of every active-low control output
`define RAR_ASSERT 1'h0
// Refresh address pattern on bits 19, 18, 17
`define RAR_A19_VAL 1'h0
`define RAR_A18_VAL 1'h1
`define RAR_A17_VAL 1'h1
// Refresh request lines all high means terminal count
`define RAR_REF_TC 3'h7
// Depth of input synchronisers
`define RAR_SYNC_DEPTH 2

`endif

/* File: verilog/rar_pkg.sv */
// Types shared by the refresh and display bus arbiter.
// Assumes rar_defs.svh is on the include path.
package rar_pkg;
   `include "rar_defs.svh"

   // Refresh timer request lines, all high at terminal count
   typedef struct packed {
      logic req_c;
      logic req_b;
      logic req_a;
   } rar_ref_t;

   // Registered arbiter outputs, all active low
   typedef struct packed {
      logic bus_req_n;
      logic rfas_n;
      logic rfae_n;
      logic crtg_n;
   } rar_ctl_t;
endpackage

/* File: verilog/rar_arbiter.sv */
// Refresh and display controller bus arbiter with refresh address drive.
// Assumes one 250 MHz clock; all pin inputs except RST_N are synchronised here.
// Functional notes
// - Refresh timer clock follows timing clock until terminal count.
// - Refresh request only when all three request lines are high.
// - From idle, refresh with grant inactive raises bus request.
// - From idle, display request with grant inactive raises bus request.
// - Bus request held; service waits for processor grant.
// - Grant, strobe negated, refresh pending: assert refresh address enable.
// - Address enable with grant then asserts refresh address strobe.
// - Refresh lasts two clocks, then everything returns idle.
// - Address bits 19,18,17 driven 0,1,1 during address enable.
// - Grant, strobe negated, display request, no refresh: grant display.
// - Display grant held while display request and grant stay.
// - Display request withdrawn: drop grant, keep bus request.
`timescale 1ns/100ps
`default_nettype none
`include "rar_defs.svh"

module rar_arbiter
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic TIMER_CLK,
   input wire rar_pkg::rar_ref_t REF_REQ,
   input wire logic CPU_ADDR_STROBE_N,
   input wire logic CPU_BUS_GRANT_N,
   input wire logic VIDEO_REQ_N,
   output logic CPU_BUS_REQ_N,
   output logic REFRESH_STROBE_N,
   output logic REFRESH_ENABLE_N,
   output logic VIDEO_GRANT_N,
   output logic REFRESH_TIMER_CLK,
   output logic ADDR19_O,
   output logic ADDR18_O,
   output logic ADDR17_O,
   output logic ADDR19_DRIVE_ENABLE,
   output logic ADDR18_DRIVE_ENABLE,
   output logic ADDR17_DRIVE_ENABLE,
   output logic VIDEO_GRANT_DRIVE_ENABLE
);
   import rar_pkg::*;

   // Pins from other clock domains: two flops before any use
   // Three edges of lag are harmless; the timing clock is far slower
   logic [6:0] sync1_ff;
   logic [6:0] sync2_ff;
   rar_ctl_t ctl_ff;
   rar_ctl_t nxt_ctl;
   logic tclk_ff;

   wire logic [6:0] pins = {TIMER_CLK, REF_REQ, CPU_ADDR_STROBE_N,
                            CPU_BUS_GRANT_N, VIDEO_REQ_N};

   always_ff @(posedge REF_CLK)
   begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
   end

   wire logic s_tclk = sync2_ff[6];
   wire logic [2:0] s_ref = sync2_ff[5:3];
   wire logic as_n = sync2_ff[2];
   wire logic bg_n = sync2_ff[1];
   wire logic vrq_n = sync2_ff[0];

   // terminal count on all three lines
   wire logic ref_pend = (s_ref == `RAR_REF_TC);

   wire logic br_n = ctl_ff.bus_req_n;
   wire logic rfas_n = ctl_ff.rfas_n;
   wire logic rfae_n = ctl_ff.rfae_n;
   wire logic crtg_n = ctl_ff.crtg_n;
   wire logic idle = rfae_n & rfas_n & crtg_n;

   wire logic rfae_start = rfas_n & ~br_n & crtg_n & ~bg_n & as_n
                           & ref_pend;
   wire logic rfae_hold = ~rfae_n & rfas_n & ~br_n & crtg_n & ~bg_n;

   wire logic br_ref = idle & br_n & bg_n & ref_pend;
   wire logic br_vid = idle & br_n & bg_n & ~vrq_n;
   wire logic br_wait = idle & ~br_n;
   wire logic br_refr = rfas_n & ~br_n & crtg_n & ~bg_n;
   wire logic br_disp = rfae_n & rfas_n & ~br_n & ~bg_n & as_n & ~vrq_n;
   wire logic br_pref = rfae_n & rfas_n & ~br_n & ~bg_n & as_n & ref_pend;
   wire logic br_after = rfae_n & rfas_n & ~br_n & ~crtg_n & ~bg_n;

   // display wins only without a pending refresh
   wire logic crtg_start = idle & ~br_n & ~bg_n & as_n & ~vrq_n
                           & ~ref_pend;
   wire logic crtg_hold = rfae_n & rfas_n & ~br_n & ~crtg_n & ~bg_n
                          & as_n & ~vrq_n;

   // Terms name the asserted level; the register stores the inverse
   always_comb
   begin
      nxt_ctl.rfae_n = ~(rfae_start | rfae_hold);
      nxt_ctl.rfas_n = ~rfae_hold;
      nxt_ctl.bus_req_n = ~(br_ref | br_vid | br_wait | br_refr | br_disp
                           | br_pref | br_after);
      nxt_ctl.crtg_n = ~(crtg_start | crtg_hold);
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         ctl_ff <= {4{`RAR_NEG}};
         tclk_ff <= `RAR_ASSERT;
      end
      else
      begin
         ctl_ff <= nxt_ctl;
         // timer clock stops at terminal count
         tclk_ff <= s_tclk & ~ref_pend;
      end
   end

   assign CPU_BUS_REQ_N = br_n;
   assign REFRESH_STROBE_N = rfas_n;
   assign REFRESH_ENABLE_N = rfae_n;
   assign VIDEO_GRANT_N = crtg_n;
   assign REFRESH_TIMER_CLK = tclk_ff;

   // refresh address only while enable is low
   assign ADDR19_O = `RAR_A19_VAL;
   assign ADDR18_O = `RAR_A18_VAL;
   assign ADDR17_O = `RAR_A17_VAL;
   assign ADDR19_DRIVE_ENABLE = ~rfae_n;
   assign ADDR18_DRIVE_ENABLE = ~rfae_n;
   assign ADDR17_DRIVE_ENABLE = ~rfae_n;
   // Display grant pin is always driven
   assign VIDEO_GRANT_DRIVE_ENABLE = 1'h1;

   // Helper: previous-cycle snapshot for assertions
   // Lets a check name the cause one clock back
   logic chk_ref_ff;
   logic chk_vrq_ff;
   logic chk_bg_ff;
   logic chk_as_ff;
   always_ff @(posedge REF_CLK)
   begin
      chk_ref_ff <= ref_pend;
      chk_vrq_ff <= vrq_n;
      chk_bg_ff <= bg_n;
      chk_as_ff <= as_n;
   end

   reset_idle_a: assert property (
      @(posedge REF_CLK) !RST_N |=> ctl_ff == {4{`RAR_NEG}})
      else $error("outputs not idle after reset");
   timer_clk_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      ref_pend |=> !REFRESH_TIMER_CLK)
      else $error("timer clock ran at terminal count");
   ref_req_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      idle && br_n && bg_n && ref_pend |=> !CPU_BUS_REQ_N)
      else $error("refresh did not request bus");
   vid_req_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      idle && br_n && bg_n && !vrq_n |=> !CPU_BUS_REQ_N)
      else $error("display did not request bus");
   wait_grant_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      idle && !br_n && bg_n |=> !CPU_BUS_REQ_N && idle)
      else $error("service started without grant");
   ref_seq_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      $fell(REFRESH_ENABLE_N) && rfas_n && !bg_n
      |=> !REFRESH_ENABLE_N && !REFRESH_STROBE_N && !CPU_BUS_REQ_N
      ##1 REFRESH_ENABLE_N && REFRESH_STROBE_N && CPU_BUS_REQ_N
          && VIDEO_GRANT_N)
      else $error("refresh cycle length wrong");
   ref_start_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      idle && !br_n && !bg_n && as_n && ref_pend
      |=> !REFRESH_ENABLE_N && REFRESH_STROBE_N && !CPU_BUS_REQ_N)
      else $error("refresh enable not asserted");
   addr_drive_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      ADDR19_DRIVE_ENABLE == !REFRESH_ENABLE_N
      && ADDR17_DRIVE_ENABLE == ADDR18_DRIVE_ENABLE
      && ADDR19_DRIVE_ENABLE == ADDR18_DRIVE_ENABLE
      && {ADDR19_O, ADDR18_O, ADDR17_O} == 3'h3)
      else $error("address drive mismatch");
   vid_grant_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      idle && !br_n && !bg_n && as_n && !vrq_n && !ref_pend
      |=> !VIDEO_GRANT_N && REFRESH_ENABLE_N)
      else $error("display grant not given");
   vid_release_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      !crtg_n && vrq_n && !bg_n |=> VIDEO_GRANT_N && !CPU_BUS_REQ_N)
      else $error("display release wrong");

   ref_strobe_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      !rfae_n && rfas_n && !br_n && crtg_n && !bg_n
      |=> !REFRESH_STROBE_N && !REFRESH_ENABLE_N)
      else $error("refresh strobe not asserted");
   vid_hold_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      !crtg_n && !br_n && !bg_n && as_n && !vrq_n
      |=> !VIDEO_GRANT_N && !CPU_BUS_REQ_N)
      else $error("display grant dropped early");
   timer_follow_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      !ref_pend |=> REFRESH_TIMER_CLK == $past(s_tclk))
      else $error("timer clock did not follow");

   // Causes below are read from the snapshots of the previous edge
   ref_only_tc_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      $fell(REFRESH_ENABLE_N) |-> chk_ref_ff)
      else $error("refresh started without terminal count");
   svc_grant_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      ($fell(REFRESH_ENABLE_N) || $fell(VIDEO_GRANT_N))
      |-> !chk_bg_ff && chk_as_ff)
      else $error("service began without bus grant");
   vid_no_ref_a: assert property (
      @(posedge REF_CLK) disable iff (!RST_N)
      $fell(VIDEO_GRANT_N) |-> !chk_vrq_ff && !chk_ref_ff)
      else $error("display granted while refresh pending");
endmodule
`default_nettype wire

/* File: test/rar_cpu_model.sv */
// Processor side model: bus grant and address strobe.
// Assumes the bench clock; changes its pins on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module rar_cpu_model
(
   input wire logic clk,
   input wire logic bus_req_n,
   input wire logic allow,
   output logic grant_n,
   output logic strobe_n
);
   initial
   begin
      grant_n = 1'h1;
      strobe_n = 1'h0;
   end
   // grant, then strobe
   // Strobe negated one cycle after grant, as a bus owner finishing
   always @(negedge clk)
   begin
      if (!allow || bus_req_n)
      begin
         grant_n <= 1'h1;
         strobe_n <= 1'h0;
      end
      else if (grant_n)
         grant_n <= 1'h0;
      else
         strobe_n <= 1'h1;
   end
endmodule
`default_nettype wire

/* File: test/test_refresh_crt_bus_arbiter.sv */
// Bench for the refresh and display bus arbiter.
// Assumes rar_cpu_model plays the processor; display driven here.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
 $display("wrong value %s exp %h got %h", n, e, g); end end
`define WAITV(s,v) for (w = 0; w < 40 && s !== v; w++) @(negedge ref_clk);
module test_refresh_crt_bus_arbiter;
   logic ref_clk = 1'h0, rst_n = 1'h0, timer_clk = 1'h0, allow = 1'h1;
   logic video_req_n = 1'h1, grant_n, strobe_n, req_n, rfs_n, rfe_n, vg_n;
   logic tclk, a19, a18, a17, e19, e18, e17, ve;
   rar_pkg::rar_ref_t ref_req = 3'h0;
   int bad_count = 0, cmp_count = 0, w;
   always #2 ref_clk = ~ref_clk;
   rar_arbiter rar_arbiter_inst (.REF_CLK(ref_clk), .RST_N(rst_n),
      .TIMER_CLK(timer_clk), .REF_REQ(ref_req), .CPU_ADDR_STROBE_N(strobe_n),
      .CPU_BUS_GRANT_N(grant_n), .VIDEO_REQ_N(video_req_n),
      .CPU_BUS_REQ_N(req_n), .REFRESH_STROBE_N(rfs_n),
      .REFRESH_ENABLE_N(rfe_n), .VIDEO_GRANT_N(vg_n),
      .REFRESH_TIMER_CLK(tclk), .ADDR19_O(a19), .ADDR18_O(a18),
      .ADDR17_O(a17), .ADDR19_DRIVE_ENABLE(e19), .ADDR18_DRIVE_ENABLE(e18),
      .ADDR17_DRIVE_ENABLE(e17), .VIDEO_GRANT_DRIVE_ENABLE(ve));
   rar_cpu_model rar_cpu_model_inst (.clk(ref_clk), .bus_req_n(req_n),
      .allow(allow), .grant_n(grant_n), .strobe_n(strobe_n));
   task conclude;
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task t_timer;
      timer_clk = 1'h1;
      repeat (5) @(negedge ref_clk);
      `CHK("tclk", 1'h1, tclk)
      timer_clk = 1'h0;
      repeat (5) @(negedge ref_clk);
      `CHK("tclk", 1'h0, tclk)
   endtask
   task t_refresh;
      allow <= 1'h0;
      timer_clk = 1'h1;
      ref_req = 3'h7;
      `WAITV(req_n, 1'h0)
      `CHK("req", 1'h0, req_n)
      repeat (6) @(negedge ref_clk);
      `CHK("rfe wait", 1'h1, rfe_n)
      `CHK("tclk tc", 1'h0, tclk)
      allow <= 1'h1;
      `WAITV(rfe_n, 1'h0)
      ref_req = 3'h0;
      `CHK("rfs", 1'h1, rfs_n)
      `CHK("addr", 6'h1F, {a19, a18, a17, e19, e18, e17})
      @(negedge ref_clk);
      `CHK("rfe rfs", 3'h0, {rfe_n, rfs_n, req_n})
      @(negedge ref_clk);
      `CHK("idle", 4'hF, {req_n, rfs_n, rfe_n, vg_n})
      `CHK("en off", 3'h0, {e19, e18, e17})
      timer_clk = 1'h0;
   endtask
   task t_display;
      ref_req = 3'h3;
      video_req_n = 1'h0;
      `WAITV(req_n, 1'h0)
      `CHK("vid req", 2'h1, {req_n, vg_n})
      `WAITV(vg_n, 1'h0)
      `CHK("vg", 2'h0, {vg_n, req_n})
      `CHK("ve", 1'h1, ve)
      repeat (8) @(negedge ref_clk);
      `CHK("vg hold", 3'h1, {vg_n, req_n, rfe_n})
      `CHK("no refresh", 1'h1, rfe_n)
      ref_req = 3'h7;
      video_req_n = 1'h1;
      `WAITV(vg_n, 1'h1)
      `CHK("req kept", 1'h0, req_n)
      `WAITV(rfe_n, 1'h0)
      ref_req = 3'h0;
      `CHK("refresh next", 2'h1, {rfe_n, vg_n})
      `WAITV(req_n, 1'h1)
      `CHK("ref done", 4'hF, {req_n, rfs_n, rfe_n, vg_n})
   endtask
   initial
   begin
      repeat (12) @(negedge ref_clk);
      `CHK("reset", 4'hF, {req_n, rfs_n, rfe_n, vg_n})
      rst_n = 1'h1;
      repeat (3) @(negedge ref_clk);
      t_timer();
      t_refresh();
      t_display();
      t_refresh();
      conclude();
   end
   initial
   begin
      #4000;
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
